// [logic/timer_pkg.sv]
// Constants and types shared by the dual timer/counter block.
// Assumes a 40 MHz system clock and a Wishbone register port.
package timer_pkg;
    // Register indices; the byte address on the bus is four times these.
    localparam logic [7:0] IDX_CTRL     = 8'h88;
    localparam logic [7:0] IDX_MODE     = 8'h89;
    localparam logic [7:0] IDX_TL0      = 8'h8A;
    localparam logic [7:0] IDX_TL1      = 8'h8B;
    localparam logic [7:0] IDX_TH0      = 8'h8C;
    localparam logic [7:0] IDX_TH1      = 8'h8D;
    localparam logic [7:0] IDX_TIMER_CLOCK_DIVIDER_CONFIG    = 8'h8E;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h90;
    localparam logic [7:0] IDX_IRQ_EN   = 8'h91;
    localparam logic [7:0] IDX_IRQ_CLR  = 8'h92;

    // Bit positions in timer_control_flags.
    localparam int B_TF1 = 7;
    localparam int B_TR1 = 6;
    localparam int B_TF0 = 5;
    localparam int B_TR0 = 4;
    localparam int B_IE1 = 3;
    localparam int B_IT1 = 2;
    localparam int B_IE0 = 1;
    localparam int B_IT0 = 0;

    // Bit positions in timer_clock_divider_config.
    localparam int B_WD_HI = 7;
    localparam int B_WD_LO = 6;
    localparam int B_T1M   = 4;
    localparam int B_T0M   = 3;

    // Event bits of the interrupt status, enable and clear registers.
    localparam int EV_TF0 = 0;
    localparam int EV_TF1 = 1;
    localparam int EV_IE0 = 2;
    localparam int EV_IE1 = 3;
    localparam int N_EV   = 4;

    localparam logic [7:0]      RST_BYTE  = 8'h00;
    localparam logic [7:0]      RST_TIMER_CLOCK_DIVIDER_CONFIG = 8'h01;
    localparam logic [N_EV-1:0] RST_EV    = 4'h0;

    // System clocks per timer tick.
    localparam logic [3:0] DIV_SLOW = 4'hC;
    localparam logic [3:0] DIV_FAST = 4'h4;

    // Reset-settle depth used by the checks.
    localparam logic [1:0] SETTLED = 2'h3;

    localparam int WDT_W = 27;

    typedef enum logic [1:0] {
        MODE_13BIT  = 2'b00,
        MODE_16BIT  = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT  = 2'b11
    } mode_t;

    typedef struct packed {
        logic  gate;
        logic  count_src;
        mode_t mode;
    } tmr_ctl_t;

    typedef struct packed {
        logic       ovf;
        logic [7:0] th;
        logic [7:0] tl;
    } step_t;
endpackage

// [logic/timer_tick_gen.sv]
// Tick source of one timer: system clock prescaler and count pin edges.
// Assumes the count pin is already synchronous to clk_i.
`timescale 1ns/1ps
module timer_tick_gen
    import timer_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic div_fast_i,
    input  wire logic count_pin_i,
    output logic      div_tick_o,
    output logic      pin_fall_o
);
    logic [3:0] div_cnt;
    logic       pin_q;

    wire  [3:0] div_last = div_fast_i ? DIV_FAST - 4'h1 : DIV_SLOW - 4'h1;
    // Greater-or-equal lets a switch to the short ratio wrap at once.
    wire        div_wrap = (div_cnt >= div_last);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt    <= 4'h0;
            div_tick_o <= 1'b0;
            pin_q      <= 1'b1;
            pin_fall_o <= 1'b0;
        end else begin
            div_cnt    <= div_wrap ? 4'h0 : div_cnt + 4'h1;
            div_tick_o <= div_wrap;
            pin_q      <= count_pin_i;
            pin_fall_o <= pin_q & ~count_pin_i;
        end
    end
endmodule

// [logic/dual_legacy_timer_counter.sv]
// Two legacy up-counting timer/counters with a Wishbone register port.
// Assumes all pins are synchronous to clk_i and a classic Wishbone master.
//
// Functional notes
// - Timer mode ticks every 12 clocks, or every 4 when div select set.
// - Count pin sampled each clock; falling edges advance the counter.
// - Source select 0 uses the divided clock, 1 uses the count pin.
// - Counting needs run set and either gating off or gate pin high.
// - Gate pin of counter zero and counter one are separate pins.
// - Mode 0 is 13 bits: high byte plus low five low-byte bits.
// - Rollover to zero in mode 0 or 1 sets the overflow flag.
// - Mode 1 cascades both bytes into one 16-bit counter.
// - Mode 2 counts low byte, reloading it from high byte on overflow.
// - Split mode: low byte uses timer zero bits, high byte timer one's.
// - During split mode timer one still runs as a baud source.
// - Timer one in mode 3 stops and holds, as if run were clear.
// - Run bits enable counting when 1, readable and writable.
// - Control register holds external interrupt flags and sense bits.
// - Watchdog field selects a timeout of 2^17, 2^20, 2^23 or 2^26.
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
module dual_legacy_timer_counter
    import timer_pkg::*;
#(
    parameter int unsigned WDT_LEN_0 = 131072,
    parameter int unsigned WDT_LEN_1 = 1048576,
    parameter int unsigned WDT_LEN_2 = 8388608,
    parameter int unsigned WDT_LEN_3 = 67108864
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [9:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic             count_pin_zero_i,
    input  wire logic             count_pin_one_i,
    input  wire logic             gate_pin_zero_i,
    input  wire logic             gate_pin_one_i,
    input  wire logic             ext_irq_pin_zero_i,
    input  wire logic             ext_irq_pin_one_i,
    output logic                  irq_o,
    output logic                  timer_one_overflow_o,
    output logic      [WDT_W-1:0] watchdog_limit_o
);
    logic [7:0]      timer_control_flags;
    logic [7:0]      timer_mode_select;
    logic [7:0]      tl0;
    logic [7:0]      th0;
    logic [7:0]      tl1;
    logic [7:0]      th1;
    logic [7:0]      timer_clock_divider_config;
    logic [N_EV-1:0] irq_stat;
    logic [N_EV-1:0] irq_en;
    logic [1:0]      xpin_q;
    logic [7:0]      next_timer_control_flags;
    logic [N_EV-1:0] events;

    // Bus decode. A write lands on the edge where the master sees ack.
    wire        req     = wb_cyc_i & wb_stb_i;
    wire        commit  = req & wb_ack_o & wb_we_i & wb_sel_i[0];
    wire [7:0]  idx     = wb_adr_i[9:2];
    wire [7:0]  wdata   = wb_dat_i[7:0];
    wire        wr_ctrl = commit & (idx == IDX_CTRL);
    wire        wr_mode = commit & (idx == IDX_MODE);
    wire        wr_tl0  = commit & (idx == IDX_TL0);
    wire        wr_tl1  = commit & (idx == IDX_TL1);
    wire        wr_th0  = commit & (idx == IDX_TH0);
    wire        wr_th1  = commit & (idx == IDX_TH1);
    wire        wr_ck   = commit & (idx == IDX_TIMER_CLOCK_DIVIDER_CONFIG);
    wire        wr_ien  = commit & (idx == IDX_IRQ_EN);
    wire        wr_iclr = commit & (idx == IDX_IRQ_CLR);

    // The clear register reads as zero; unmapped words read as zero.
    wire [7:0]  rd_byte =
        (idx == IDX_CTRL)     ? timer_control_flags :
        (idx == IDX_MODE)     ? timer_mode_select :
        (idx == IDX_TL0)      ? tl0 :
        (idx == IDX_TL1)      ? tl1 :
        (idx == IDX_TH0)      ? th0 :
        (idx == IDX_TH1)      ? th1 :
        (idx == IDX_TIMER_CLOCK_DIVIDER_CONFIG)    ? timer_clock_divider_config :
        (idx == IDX_IRQ_STAT) ? {4'h0, irq_stat} :
        (idx == IDX_IRQ_EN)   ? {4'h0, irq_en} : RST_BYTE;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
            if (req & ~wb_ack_o) begin
                wb_dat_o <= {24'h00_0000, rd_byte};
            end
        end
    end

    // Tick sources, one per timer.
    wire tmr_ctl_t c0 = tmr_ctl_t'(timer_mode_select[3:0]);
    wire tmr_ctl_t c1 = tmr_ctl_t'(timer_mode_select[7:4]);
    wire [1:0] div_fast = {timer_clock_divider_config[B_T1M], timer_clock_divider_config[B_T0M]};
    wire [1:0] cnt_pin  = {count_pin_one_i, count_pin_zero_i};
    logic [1:0] div_tick;
    logic [1:0] pin_fall;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_tick
            timer_tick_gen u_tick (
                .clk_i       (clk_i),
                .rst_i       (rst_i),
                .div_fast_i  (div_fast[gi]),
                .count_pin_i (cnt_pin[gi]),
                .div_tick_o  (div_tick[gi]),
                .pin_fall_o  (pin_fall[gi])
            );
        end
    endgenerate

    // One count step for modes 0 to 2; split low byte uses the default arm.
    function automatic step_t count_step(input mode_t      m,
                                         input logic [7:0] th,
                                         input logic [7:0] tl);
        step_t       r;
        logic [12:0] s13;
        logic [15:0] s16;
        s13   = {th, tl[4:0]} + 13'h1;
        s16   = {th, tl} + 16'h1;
        r.ovf = &tl;
        r.th  = th;
        r.tl  = tl + 8'h1;
        case (m)
            MODE_13BIT: begin
                // Upper three low-byte bits are left alone.
                r.ovf = &{th, tl[4:0]};
                r.th  = s13[12:5];
                r.tl  = {tl[7:5], s13[4:0]};
            end
            MODE_16BIT: begin
                r.ovf = &{th, tl};
                r.th  = s16[15:8];
                r.tl  = s16[7:0];
            end
            MODE_RELOAD: begin
                if (&tl) begin
                    r.tl = th;
                end
            end
            default: begin
            end
        endcase
        return r;
    endfunction

    wire   t0_split = (c0.mode == MODE_SPLIT);
    wire   t1_hold  = (c1.mode == MODE_SPLIT);
    wire   src0     = c0.count_src ? pin_fall[0] : div_tick[0];
    wire   src1     = c1.count_src ? pin_fall[1] : div_tick[1];
    wire   en0      = timer_control_flags[B_TR0] & (~c0.gate | gate_pin_zero_i);
    // In split mode the run bit belongs to the high byte of timer zero,
    // so timer one free-runs for the baud generator.
    wire   en1      = (timer_control_flags[B_TR1] | t0_split)
                      & (~c1.gate | gate_pin_one_i) & ~t1_hold;
    wire   inc0     = en0 & src0;
    wire   inc1     = en1 & src1;
    wire step_t st0 = count_step(c0.mode, th0, tl0);
    wire step_t st1 = count_step(c1.mode, th1, tl1);
    wire   ovf0     = inc0 & st0.ovf;
    wire   ovf1     = inc1 & st1.ovf;
    wire   th0_inc  = t0_split & timer_control_flags[B_TR1] & div_tick[0];
    wire   ovf_th0  = th0_inc & (&th0);
    wire   tf1_set  = t0_split ? ovf_th0 : ovf1;

    // Software loads take precedence over a count in the same cycle.
    wire [7:0] next_tl0 = wr_tl0 ? wdata : (inc0 ? st0.tl : tl0);
    wire [7:0] next_th0 = wr_th0 ? wdata :
                          t0_split ? (th0_inc ? th0 + 8'h1 : th0) :
                          (inc0 ? st0.th : th0);
    wire [7:0] next_tl1 = wr_tl1 ? wdata : (inc1 ? st1.tl : tl1);
    wire [7:0] next_th1 = wr_th1 ? wdata : (inc1 ? st1.th : th1);

    // External interrupt pins: falling edge or low level per sense bit.
    wire [1:0] xpin  = {ext_irq_pin_one_i, ext_irq_pin_zero_i};
    wire [1:0] xfall = xpin_q & ~xpin;
    wire [1:0] xsens = {timer_control_flags[B_IT1], timer_control_flags[B_IT0]};
    wire [1:0] xset  = (xsens & xfall) | (~xsens & ~xpin);

    // Hardware sets win over a software clear in the same cycle.
    always_comb begin
        next_timer_control_flags        = wr_ctrl ? wdata : timer_control_flags;
        next_timer_control_flags[B_TF0] = next_timer_control_flags[B_TF0] | ovf0;
        next_timer_control_flags[B_TF1] = next_timer_control_flags[B_TF1] | tf1_set;
        next_timer_control_flags[B_IE0] = next_timer_control_flags[B_IE0] | xset[0];
        next_timer_control_flags[B_IE1] = next_timer_control_flags[B_IE1] | xset[1];
        events           = RST_EV;
        events[EV_TF0]   = ovf0;
        events[EV_TF1]   = tf1_set;
        events[EV_IE0]   = xset[0];
        events[EV_IE1]   = xset[1];
    end

    wire [N_EV-1:0] iclr = wr_iclr ? wdata[N_EV-1:0] : RST_EV;
    wire [1:0]      wsel = timer_clock_divider_config[B_WD_HI:B_WD_LO];
    wire [WDT_W-1:0] wdt_next =
        (wsel == 2'b00) ? WDT_W'(WDT_LEN_0) :
        (wsel == 2'b01) ? WDT_W'(WDT_LEN_1) :
        (wsel == 2'b10) ? WDT_W'(WDT_LEN_2) : WDT_W'(WDT_LEN_3);

    assign irq_o = |(irq_stat & irq_en);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_control_flags                 <= RST_BYTE;
            timer_mode_select                 <= RST_BYTE;
            tl0                  <= RST_BYTE;
            th0                  <= RST_BYTE;
            tl1                  <= RST_BYTE;
            th1                  <= RST_BYTE;
            timer_clock_divider_config                <= RST_TIMER_CLOCK_DIVIDER_CONFIG;
            irq_stat             <= RST_EV;
            irq_en               <= RST_EV;
            xpin_q               <= 2'b11;
            timer_one_overflow_o <= 1'b0;
            watchdog_limit_o     <= '0;
        end else begin
            timer_control_flags                 <= next_timer_control_flags;
            timer_mode_select                 <= wr_mode ? wdata : timer_mode_select;
            tl0                  <= next_tl0;
            th0                  <= next_th0;
            tl1                  <= next_tl1;
            th1                  <= next_th1;
            timer_clock_divider_config                <= wr_ck ? wdata : timer_clock_divider_config;
            irq_stat             <= (irq_stat & ~iclr) | events;
            irq_en               <= wr_ien ? wdata[N_EV-1:0] : irq_en;
            xpin_q               <= xpin;
            timer_one_overflow_o <= ovf1;
            watchdog_limit_o     <= wdt_next;
        end
    end

    // ------------------------------------------------------------------
    // Checks.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Pre-reset pin history must not feed edge checks.
    logic [1:0] settle;
    logic [3:0] gap0;
    logic       t0m_q;
    logic       same0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            settle <= 2'h0;
            gap0   <= 4'h0;
            t0m_q  <= 1'b0;
            same0  <= 1'b0;
        end else begin
            settle <= (settle == SETTLED) ? settle : settle + 2'h1;
            t0m_q  <= timer_clock_divider_config[B_T0M];
            same0  <= (div_tick[0] | same0) & (t0m_q == timer_clock_divider_config[B_T0M]);
            gap0   <= div_tick[0] ? 4'h0 : gap0 + 4'h1;
        end
    end

    property p_div_period;
        div_tick[0] && same0 |->
            gap0 == (t0m_q ? DIV_FAST - 4'h1 : DIV_SLOW - 4'h1);
    endproperty
    a_div_period: assert property (p_div_period)
        else $error("timer zero prescaler period wrong");

    property p_fall_detect;
        settle == SETTLED |->
            pin_fall[0] == ($past(count_pin_zero_i, 2)
                            && !$past(count_pin_zero_i));
    endproperty
    a_fall_detect: assert property (p_fall_detect)
        else $error("count pin falling edge missed or false");

    property p_pin_source;
        en0 && c0.count_src && !pin_fall[0] && !wr_tl0 && !wr_th0
            && c0.mode == MODE_16BIT |=> {th0, tl0} == $past({th0, tl0});
    endproperty
    a_pin_source: assert property (p_pin_source)
        else $error("counter moved without a pin edge");

    property p_gate_hold;
        !en0 && !wr_tl0 && !wr_th0 && c0.mode == MODE_16BIT
            |=> {th0, tl0} == $past({th0, tl0});
    endproperty
    a_gate_hold: assert property (p_gate_hold)
        else $error("timer zero counted while disabled");

    property p_timer_step;
        en0 && !c0.count_src && div_tick[0] && !wr_tl0 && !wr_th0
            && c0.mode == MODE_16BIT
            |=> {th0, tl0} == $past({th0, tl0}) + 16'h1;
    endproperty
    a_timer_step: assert property (p_timer_step)
        else $error("sixteen bit timer did not step by one");

    property p_roll13;
        inc0 && c0.mode == MODE_13BIT && th0 == 8'hFF
            && tl0[4:0] == 5'h1F && !wr_tl0 && !wr_th0
            |=> timer_control_flags[B_TF0] && th0 == 8'h00 && tl0[4:0] == 5'h00;
    endproperty
    a_roll13: assert property (p_roll13)
        else $error("thirteen bit rollover wrong");

    property p_reload;
        inc0 && c0.mode == MODE_RELOAD && tl0 == 8'hFF
            && !wr_tl0 && !wr_th0
            |=> tl0 == $past(th0) && th0 == $past(th0) && timer_control_flags[B_TF0];
    endproperty
    a_reload: assert property (p_reload)
        else $error("auto reload did not load the low byte");

    property p_split_high;
        t0_split && timer_control_flags[B_TR1] && div_tick[0] && th0 == 8'hFF
            && !wr_th0 |=> timer_control_flags[B_TF1] && th0 == 8'h00;
    endproperty
    a_split_high: assert property (p_split_high)
        else $error("split high byte overflow not on timer one flag");

    property p_baud_pulse;
        t0_split && ovf1 |=> timer_one_overflow_o && !timer_control_flags[B_TF1]
            || $past(ovf_th0) || $past(wr_ctrl) || $past(timer_control_flags[B_TF1]);
    endproperty
    a_baud_pulse: assert property (p_baud_pulse)
        else $error("timer one overflow in split mode misrouted");

    property p_t1_hold;
        t1_hold && !wr_tl1 && !wr_th1
            |=> {th1, tl1} == $past({th1, tl1});
    endproperty
    a_t1_hold: assert property (p_t1_hold)
        else $error("timer one counted in mode 3");

    property p_edge_flag;
        timer_control_flags[B_IT0] && xfall[0] |=> timer_control_flags[B_IE0] && irq_stat[EV_IE0];
    endproperty
    a_edge_flag: assert property (p_edge_flag)
        else $error("external edge did not set its flag");

    property p_wdt_sel;
        wsel == 2'b01 |=> watchdog_limit_o == WDT_W'(WDT_LEN_1);
    endproperty
    a_wdt_sel: assert property (p_wdt_sel)
        else $error("watchdog timeout select wrong");

    property p_set_wins;
        wr_ctrl && !wdata[B_TF0] && ovf0 |=> timer_control_flags[B_TF0];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("overflow lost against software clear");

    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack held longer than one cycle");
endmodule

// [logic/timer_pkg_unused_guard.sv]
// Holds no logic; the package and both modules live in their own files.

// [dv/timer_pin_model.sv]
// Pin-side model of the timer block: count, gate and external irq pins.
// Assumes the bench calls its tasks from a single process.
`timescale 1ns/1ps
module timer_pin_model (
    input  wire logic clk_i,
    output logic      count_pin_zero_o,
    output logic      count_pin_one_o,
    output logic      gate_pin_zero_o,
    output logic      gate_pin_one_o,
    output logic      ext_irq_pin_zero_o,
    output logic      ext_irq_pin_one_o
);
    // Port pins idle high, as with the port pull-ups enabled.
    logic [5:0] pins = 6'h3F;

    assign {ext_irq_pin_one_o, ext_irq_pin_zero_o, gate_pin_one_o,
            gate_pin_zero_o, count_pin_one_o, count_pin_zero_o} = pins;

    task automatic set_pin(input int k, input logic v);
        @(posedge clk_i);
        pins[k] <= v;
    endtask

    // Each phase lasts three clocks, so a per-clock sampler cannot miss it.
    task automatic pulse(input int k, input int n);
        repeat (n) begin
            set_pin(k, 1'b0);
            repeat (2) @(posedge clk_i);
            set_pin(k, 1'b1);
            repeat (2) @(posedge clk_i);
        end
    endtask
endmodule

// [dv/tb_dual_legacy_timer_counter.sv]
// Self-checking bench for the dual timer/counter block.
// Assumes the package, design files and pin model are compiled first.
`timescale 1ns/1ps
module tb_dual_legacy_timer_counter;
    import timer_pkg::*;
    typedef struct packed {
        logic [7:0] idx;
        logic       we;
        logic [7:0] d;
        logic [7:0] e;
    } row_t;
    typedef struct packed {
        logic       t;
        logic [3:0] m;
        logic [7:0] th, tl;
        logic       g;
        logic [3:0] n;
        logic [7:0] eth, etl, msk;
        logic       ovf;
    } case_t;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [9:0]  wb_adr = 10'h000;
    logic [3:0]  wb_sel = 4'h1;
    logic [3:0]  lanes = 4'h1;
    logic [31:0] wb_dat = 32'h0000_0000;
    logic [31:0] dat_o;
    logic        ack, irq, t1_ovf, cp0, cp1, gp0, gp1, ip0, ip1;
    logic [26:0] wdt;
    logic [7:0]  q;
    int          n_errors = 0;
    int          total_checks = 0;
    int          hits = 0;
    row_t rows [16] = '{
        '{IDX_CTRL, 1'h0, 8'h00, 8'h00}, '{IDX_MODE, 1'h0, 8'h00, 8'h00},
        '{IDX_TL0, 1'h0, 8'h00, 8'h00}, '{IDX_TL1, 1'h0, 8'h00, 8'h00},
        '{IDX_TH0, 1'h0, 8'h00, 8'h00}, '{IDX_TH1, 1'h0, 8'h00, 8'h00},
        '{IDX_TIMER_CLOCK_DIVIDER_CONFIG, 1'h0, 8'h00, 8'h01}, '{IDX_IRQ_STAT, 1'h0, 8'h00, 8'h00},
        '{IDX_IRQ_EN, 1'h0, 8'h00, 8'h00}, '{8'h50, 1'h0, 8'h00, 8'h00},
        '{IDX_MODE, 1'h1, 8'h5A, 8'h5A}, '{IDX_TH1, 1'h1, 8'hA5, 8'hA5},
        '{IDX_IRQ_EN, 1'h1, 8'h0F, 8'h0F}, '{IDX_IRQ_CLR, 1'h1, 8'h0F, 8'h00},
        '{8'h50, 1'h1, 8'hFF, 8'h00}, '{IDX_CTRL, 1'h1, 8'h05, 8'h05}};
    case_t cases [10] = '{
        '{1'h0, 4'h5, 8'hFF, 8'hFF, 1'h1, 4'h1, 8'h00, 8'h00, 8'hFF, 1'h1},
        '{1'h0, 4'h4, 8'hFF, 8'h1F, 1'h1, 4'h1, 8'h00, 8'h00, 8'h1F, 1'h1},
        '{1'h0, 4'h4, 8'h00, 8'h1F, 1'h1, 4'h1, 8'h01, 8'h00, 8'h1F, 1'h0},
        '{1'h0, 4'h6, 8'hF0, 8'hFF, 1'h1, 4'h1, 8'hF0, 8'hF0, 8'hFF, 1'h1},
        '{1'h0, 4'hD, 8'h00, 8'h00, 1'h0, 4'h3, 8'h00, 8'h00, 8'hFF, 1'h0},
        '{1'h0, 4'hD, 8'h00, 8'h00, 1'h1, 4'h3, 8'h00, 8'h03, 8'hFF, 1'h0},
        '{1'h1, 4'hD, 8'h00, 8'h00, 1'h0, 4'h2, 8'h00, 8'h00, 8'hFF, 1'h0},
        '{1'h1, 4'h6, 8'hF0, 8'hFF, 1'h1, 4'h1, 8'hF0, 8'hF0, 8'hFF, 1'h1},
        '{1'h1, 4'h7, 8'h00, 8'h00, 1'h1, 4'h3, 8'h00, 8'h00, 8'hFF, 1'h0},
        '{1'h0, 4'h7, 8'h00, 8'hFF, 1'h1, 4'h1, 8'h00, 8'h00, 8'hFF, 1'h1}};

    always #12.5 clk_i = ~clk_i;

    dual_legacy_timer_counter i_dual_legacy_timer_counter (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .count_pin_zero_i(cp0), .count_pin_one_i(cp1),
        .gate_pin_zero_i(gp0), .gate_pin_one_i(gp1),
        .ext_irq_pin_zero_i(ip0), .ext_irq_pin_one_i(ip1), .irq_o(irq),
        .timer_one_overflow_o(t1_ovf), .watchdog_limit_o(wdt));
    timer_pin_model i_timer_pin_model (
        .clk_i(clk_i), .count_pin_zero_o(cp0), .count_pin_one_o(cp1),
        .gate_pin_zero_o(gp0), .gate_pin_one_o(gp1),
        .ext_irq_pin_zero_o(ip0), .ext_irq_pin_one_o(ip1));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Holds the request until ack is sampled; the watchdog cuts a hang.
    task automatic wb(input logic [7:0] idx, input logic we,
                      input logic [7:0] d);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_sel <= lanes;
        wb_adr <= {idx, 2'h0};
        wb_dat <= {24'h00_0000, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        q = dat_o[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        wb(idx, 1'b1, d);
    endtask

    task automatic rd(input logic [7:0] idx);
        wb(idx, 1'b0, 8'h00);
    endtask

    task automatic run_case(input case_t c);
        logic [7:0] run;
        logic [7:0] flag;
        run = c.t ? 8'h40 : 8'h10;
        flag = c.t ? 8'h80 : 8'h20;
        wr(IDX_CTRL, 8'h00);
        wr(IDX_MODE, c.t ? {c.m, 4'h0} : {4'h0, c.m});
        wr(IDX_TH0 + c.t, c.th);
        wr(IDX_TL0 + c.t, c.tl);
        i_timer_pin_model.set_pin(2 + c.t, c.g);
        wr(IDX_CTRL, run);
        i_timer_pin_model.pulse(c.t, c.n);
        repeat (4) @(posedge clk_i);
        rd(IDX_CTRL);
        chk(q, run | (c.ovf ? flag : 8'h00));
        wr(IDX_CTRL, 8'h00);
        rd(IDX_TH0 + c.t);
        chk(q, c.eth);
        rd(IDX_TL0 + c.t);
        chk(q & c.msk, c.etl);
        i_timer_pin_model.set_pin(2 + c.t, 1'b1);
    endtask

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        wrap_up();
    end

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].we) begin
                wr(rows[i].idx, rows[i].d);
            end
            rd(rows[i].idx);
            chk(q, rows[i].e);
        end
        $display("test registers done");
        foreach (cases[i]) begin
            run_case(cases[i]);
        end
        $display("test modes done");
        for (int d = 0; d < 2; d++) begin
            wr(IDX_MODE, 8'h01);
            wr(IDX_TL0, 8'h00);
            wr(IDX_TIMER_CLOCK_DIVIDER_CONFIG, d ? 8'h09 : 8'h01);
            wr(IDX_CTRL, 8'h10);
            repeat (120) @(posedge clk_i);
            wr(IDX_CTRL, 8'h00);
            rd(IDX_TL0);
            chk(q >= (d ? 29 : 9) && q <= (d ? 32 : 12), 1'b1);
        end
        $display("test divider done");
        for (int k = 0; k < 4; k++) begin
            wr(IDX_TIMER_CLOCK_DIVIDER_CONFIG, {k[1:0], 6'h01});
            repeat (3) @(posedge clk_i);
            chk({5'h00, wdt}, 32'h0002_0000 << (3 * k));
        end
        $display("test watchdog done");
        // Timer one free-runs in split mode: one pulse, no flag.
        wr(IDX_TH1, 8'hFF);
        wr(IDX_TL1, 8'h1F);
        wr(IDX_MODE, 8'h03);
        repeat (40) begin
            @(posedge clk_i);
            if (t1_ovf === 1'b1) begin
                hits++;
            end
        end
        chk(hits, 32'h0000_0001);
        rd(IDX_CTRL);
        chk(q, 8'h00);
        wr(IDX_TH0, 8'hFF);
        wr(IDX_CTRL, 8'h40);
        repeat (16) @(posedge clk_i);
        rd(IDX_CTRL);
        chk(q, 8'hC0);
        wr(IDX_CTRL, 8'h00);
        wr(IDX_MODE, 8'h01);
        $display("test split mode done");
        wr(IDX_IRQ_CLR, 8'h0F);
        wr(IDX_IRQ_EN, 8'h00);
        wr(IDX_CTRL, 8'h01);
        i_timer_pin_model.pulse(4, 1);
        rd(IDX_CTRL);
        chk(q, 8'h03);
        rd(IDX_IRQ_STAT);
        chk(q, 8'h04);
        chk(irq, 1'b0);
        wr(IDX_IRQ_EN, 8'h04);
        @(posedge clk_i);
        chk(irq, 1'b1);
        wr(IDX_IRQ_CLR, 8'h04);
        @(posedge clk_i);
        chk(irq, 1'b0);
        wr(IDX_CTRL, 8'h00);
        i_timer_pin_model.set_pin(5, 1'b0);
        repeat (3) @(posedge clk_i);
        rd(IDX_CTRL);
        chk(q, 8'h08);
        i_timer_pin_model.set_pin(5, 1'b1);
        $display("test interrupts done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(IDX_TIMER_CLOCK_DIVIDER_CONFIG);
        chk(q, 8'h01);
        rd(IDX_IRQ_EN);
        chk(q, 8'h00);
        // A write with lane zero off is acknowledged but not stored.
        lanes = 4'h0;
        wr(IDX_TH1, 8'h11);
        lanes = 4'h1;
        rd(IDX_TH1);
        chk(q, 8'h00);
        $display("test second reset done");
        wrap_up();
    end
endmodule
